// ---- core/fts_pkg.sv ----
// Purpose: constants shared by the fan and thermal supervisor
// Assumes: sys_clk at 25 MHz, synchronous active-high reset
// Notes:   long counts are overridable parameters of the top module
//
// Overview of operation
// - at power-up fans off, after about 4 s brief full speed, then off
// - welding at or below 146 A selects low fan speed
// - current above 146 A selects full fan speed
// - fans keep running 6.5 minutes after welding ends
// - after current drops from above 146 A, hold full speed 6.5 minutes
// - overtemperature forces high fan speed until temperature is normal
// - any thermal cutout open stops power output and reports fault 6
// - restart refused until every thermal cutout has reclosed
// - start-up shows indicator a red, then all three green
// - once the application runs, indicator a flashes green continuously
// - at power-up load fieldbus bit rate 400 kbit/s from the processor
package fts_pkg;
  localparam longint CLK_HZ          = 25_000_000;
  localparam longint FAN_DELAY_MS    = 4000;
  localparam longint FAN_BLIP_MS     = 2000;
  localparam longint RUNON_DECIMIN   = 65;
  localparam longint LAMP_RED_MS     = 1000;
  localparam longint LAMP_FLASH_MS   = 500;
  localparam int     CNT_W           = 34;
  localparam logic [CNT_W-1:0] FAN_DELAY_CYC =
    CNT_W'(FAN_DELAY_MS * CLK_HZ / 1000);
  localparam logic [CNT_W-1:0] FAN_BLIP_CYC =
    CNT_W'(FAN_BLIP_MS * CLK_HZ / 1000);
  localparam logic [CNT_W-1:0] RUNON_CYC =
    CNT_W'(RUNON_DECIMIN * 6 * CLK_HZ);
  localparam logic [CNT_W-1:0] LAMP_RED_CYC =
    CNT_W'(LAMP_RED_MS * CLK_HZ / 1000);
  localparam logic [CNT_W-1:0] LAMP_FLASH_CYC =
    CNT_W'(LAMP_FLASH_MS * CLK_HZ / 1000);
  localparam logic [9:0]  HIGH_CURRENT_A  = 10'h092;
  localparam logic [9:0]  FIELDBUS_KBPS   = 10'h190;
  localparam logic [4:0]  FAULT_THERMAL   = 5'h06;
  localparam logic [4:0]  FAULT_NONE      = 5'h00;
  typedef enum logic [4:0] {
    FAN_WAIT  = 5'h01,
    FAN_BLIP  = 5'h02,
    FAN_IDLE  = 5'h04,
    FAN_WELD  = 5'h08,
    FAN_RUNON = 5'h10
  } fts_fan_state_t;
  typedef enum logic [2:0] {
    LAMP_RED   = 3'h1,
    LAMP_GREEN = 3'h2,
    LAMP_RUN   = 3'h4
  } fts_lamp_state_t;
endpackage : fts_pkg

// ---- core/fts_lamp_if.sv ----
// Purpose: carries start-up progress to the indicator driver
// Assumes: single clock domain
// Notes:   the driver returns its four lamp levels
`timescale 1ns/1ps
`default_nettype none
interface fts_lamp_if;
  logic appRunning;
  logic indARed;
  logic indAGreen;
  logic indBGreen;
  logic indCGreen;
  modport ctrl (output appRunning, input indARed, indAGreen, indBGreen,
                indCGreen);
  modport lamp (input appRunning, output indARed, indAGreen, indBGreen,
                indCGreen);
endinterface : fts_lamp_if
`default_nettype wire

// ---- core/fts_status_lamps.sv ----
// Purpose: start-up and run indicator sequencing
// Assumes: lamp outputs are registered
// Notes:   green stays steady until the application reports running
`timescale 1ns/1ps
`default_nettype none
module fts_status_lamps #(
  parameter logic [fts_pkg::CNT_W-1:0] RED_CYC   = fts_pkg::LAMP_RED_CYC,
  parameter logic [fts_pkg::CNT_W-1:0] FLASH_CYC = fts_pkg::LAMP_FLASH_CYC
) (
  input  wire logic   sys_clk,
  input  wire logic   reset,
  fts_lamp_if.lamp    lamps
);
  fts_pkg::fts_lamp_state_t     state_reg;
  fts_pkg::fts_lamp_state_t     state_next;
  logic [fts_pkg::CNT_W-1:0]    cnt_reg;
  logic                         flash_reg;
  wire                          cntDone = (cnt_reg == '0);
  wire                          flashOn = flash_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      fts_pkg::LAMP_RED:   if (cntDone) state_next = fts_pkg::LAMP_GREEN;
      fts_pkg::LAMP_GREEN:
        if (lamps.appRunning)
          state_next = fts_pkg::LAMP_RUN;
      fts_pkg::LAMP_RUN:   state_next = fts_pkg::LAMP_RUN;
      default:             state_next = fts_pkg::LAMP_RED;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= fts_pkg::LAMP_RED;
      cnt_reg   <= RED_CYC;
      flash_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next != state_reg)
        cnt_reg <= FLASH_CYC;
      else if (!cntDone)
        cnt_reg <= cnt_reg - 1'b1;
      else if (state_reg == fts_pkg::LAMP_RUN)
      begin
        cnt_reg   <= FLASH_CYC;
        flash_reg <= ~flash_reg;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      lamps.indARed   <= 1'b0;
      lamps.indAGreen <= 1'b0;
      lamps.indBGreen <= 1'b0;
      lamps.indCGreen <= 1'b0;
    end
    else
    begin
      lamps.indARed   <= (state_next == fts_pkg::LAMP_RED);
      lamps.indAGreen <= (state_next == fts_pkg::LAMP_GREEN) ||
                         ((state_next == fts_pkg::LAMP_RUN) && flashOn);
      lamps.indBGreen <= (state_next == fts_pkg::LAMP_GREEN);
      lamps.indCGreen <= (state_next == fts_pkg::LAMP_GREEN);
    end
  end
endmodule : fts_status_lamps
`default_nettype wire

// ---- core/fts_supervisor.sv ----
// Purpose: fan sequencing, thermal stop and start-up bookkeeping
// Assumes: inputs synchronous to sys_clk; reset marks mains power-up
// Notes:   current arrives as whole amperes; run-on counts are 34 bits
`timescale 1ns/1ps
`default_nettype none
module fts_supervisor #(
  parameter logic [fts_pkg::CNT_W-1:0] DELAY_CYC = fts_pkg::FAN_DELAY_CYC,
  parameter logic [fts_pkg::CNT_W-1:0] BLIP_CYC  = fts_pkg::FAN_BLIP_CYC,
  parameter logic [fts_pkg::CNT_W-1:0] RUNON_CYC = fts_pkg::RUNON_CYC,
  parameter logic [fts_pkg::CNT_W-1:0] RED_CYC   = fts_pkg::LAMP_RED_CYC,
  parameter logic [fts_pkg::CNT_W-1:0] FLASH_CYC = fts_pkg::LAMP_FLASH_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        weldActive,
  input  wire logic [9:0]  loadCurrentAmps,
  input  wire logic        overTemp,
  input  wire logic        transformer_thermal_cutout,
  input  wire logic        heatsink_thermal_cutout,
  input  wire logic        restartRequest,
  input  wire logic        appRunning,
  input  wire logic [9:0]  procBitRateKbps,
  output logic             fanOn,
  output logic             fanFullSpeed,
  output logic             powerEnable,
  output logic [4:0]       faultCode,
  output logic             fieldbusRateLoad,
  output logic [9:0]       fieldbusRateKbps,
  output logic             status_indicator_a_red,
  output logic             status_indicator_a_green,
  output logic             status_indicator_b,
  output logic             status_indicator_c
);
  fts_pkg::fts_fan_state_t     state_reg;
  fts_pkg::fts_fan_state_t     state_next;
  logic [fts_pkg::CNT_W-1:0]   timer_reg;
  logic [fts_pkg::CNT_W-1:0]   timer_next;
  logic [fts_pkg::CNT_W-1:0]   hold_reg;
  logic                        highPrev_reg;
  logic                        loaded_reg;
  logic                        tripped_reg;
  fts_lamp_if                  lampBus ();

  // saturating decrement shared by the sequence timer and the speed hold
  function automatic logic [fts_pkg::CNT_W-1:0] count_down(
    input logic [fts_pkg::CNT_W-1:0] value
  );
    return (value == '0) ? value : value - 1'b1;
  endfunction : count_down

  // cutout inputs are high when the switch is open
  wire cutoutOpen  = transformer_thermal_cutout | heatsink_thermal_cutout;
  wire highCurrent = (loadCurrentAmps > fts_pkg::HIGH_CURRENT_A);
  wire highWeld    = highCurrent && weldActive;
  wire timerDone   = (timer_reg == '0);
  wire holdActive  = (hold_reg != '0);
  wire weldOrRun   = (state_next == fts_pkg::FAN_WELD) ||
                     (state_next == fts_pkg::FAN_RUNON);
  wire fanRunNext  = weldOrRun || (state_next == fts_pkg::FAN_BLIP) ||
                     overTemp;
  // the hold loads one edge after the drop, so highPrev_reg bridges it
  wire keepFull    = highCurrent || highPrev_reg || holdActive;
  wire fullNext    = overTemp ||
                     (state_next == fts_pkg::FAN_BLIP) ||
                     (weldOrRun && keepFull);
  // a restart needs the request high while both cutouts are closed; a request held since the trip counts
  wire restartOk   = tripped_reg && !cutoutOpen && restartRequest;
  wire loadRate    = !loaded_reg;

  assign lampBus.appRunning = appRunning;

  always_comb
  begin
    state_next = state_reg;
    // every state counts down; a state that needs a fresh span reloads it
    timer_next = count_down(timer_reg);
    case (state_reg)
      // weld requests during the start-up wait and blip are ignored
      fts_pkg::FAN_WAIT:
        if (timerDone)
        begin
          state_next = fts_pkg::FAN_BLIP;
          timer_next = BLIP_CYC;
        end
      fts_pkg::FAN_BLIP:
        if (timerDone)
          state_next = fts_pkg::FAN_IDLE;
      fts_pkg::FAN_IDLE:
        if (weldActive)
          state_next = fts_pkg::FAN_WELD;
      fts_pkg::FAN_WELD:
        if (!weldActive)
        begin
          state_next = fts_pkg::FAN_RUNON;
          timer_next = RUNON_CYC;
        end
      fts_pkg::FAN_RUNON:
        if (weldActive)
          state_next = fts_pkg::FAN_WELD;
        else if (timerDone)
          state_next = fts_pkg::FAN_IDLE;
      default:
      begin
        state_next = fts_pkg::FAN_IDLE;
        timer_next = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      // the start-up wait counts from the release of reset
      state_reg <= fts_pkg::FAN_WAIT;
      timer_reg <= DELAY_CYC;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // hold restarts on every falling edge of the high-current condition
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      hold_reg     <= '0;
      highPrev_reg <= 1'b0;
    end
    else
    begin
      highPrev_reg <= highWeld;
      if (highWeld)
        hold_reg <= '0;
      else if (highPrev_reg)
        hold_reg <= RUNON_CYC;
      else if (holdActive)
        hold_reg <= count_down(hold_reg);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fanOn        <= 1'b0;
      fanFullSpeed <= 1'b0;
    end
    else
    begin
      // low speed whenever the fans run without a full-speed request
      fanOn        <= fanRunNext;
      fanFullSpeed <= fullNext;
    end
  end

  // trip is held while a cutout stays open, so a new opening never loses
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tripped_reg <= 1'b0;
      powerEnable <= 1'b0;
      faultCode   <= fts_pkg::FAULT_NONE;
    end
    // an opening in the same cycle as a restart request wins
    else if (cutoutOpen)
    begin
      tripped_reg <= 1'b1;
      powerEnable <= 1'b0;
      faultCode   <= fts_pkg::FAULT_THERMAL;
    end
    else if (restartOk)
    begin
      tripped_reg <= 1'b0;
      powerEnable <= 1'b1;
      faultCode   <= fts_pkg::FAULT_NONE;
    end
    else if (!tripped_reg)
      powerEnable <= 1'b1;
  end

  // bit rate is captured once, one edge after reset release
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      loaded_reg       <= 1'b0;
      fieldbusRateLoad <= 1'b0;
      // nominal rate until the processor's copy lands
      fieldbusRateKbps <= fts_pkg::FIELDBUS_KBPS;
    end
    else
    begin
      loaded_reg       <= 1'b1;
      fieldbusRateLoad <= loadRate;
      if (loadRate)
        fieldbusRateKbps <= procBitRateKbps;
    end
  end

  // indicator sequencing sits in its own module behind the interface
  fts_status_lamps #(
    .RED_CYC   (RED_CYC),
    .FLASH_CYC (FLASH_CYC)
  ) lampDrv (
    .sys_clk (sys_clk),
    .reset   (reset),
    .lamps   (lampBus)
  );

  // indicator levels come straight from the driver's registers
  assign status_indicator_a_red   = lampBus.indARed;
  assign status_indicator_a_green = lampBus.indAGreen;
  assign status_indicator_b       = lampBus.indBGreen;
  assign status_indicator_c       = lampBus.indCGreen;
endmodule : fts_supervisor
`default_nettype wire

// ---- test/fts_supervisor_monitor.sv ----
// Purpose: port checker for the fan and thermal supervisor
// Assumes: one clock, synchronous active-high reset
// Notes:   a counter stands in for the start-up wait
`timescale 1ns/1ps
`default_nettype none
module fts_supervisor_monitor #(
  parameter logic [fts_pkg::CNT_W-1:0] DELAY_CYC = 10,
  parameter logic [fts_pkg::CNT_W-1:0] FLASH_CYC = 3
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       weldActive,
  input wire logic [9:0] loadCurrentAmps,
  input wire logic       overTemp,
  input wire logic       transformer_thermal_cutout,
  input wire logic       heatsink_thermal_cutout,
  input wire logic       restartRequest,
  input wire logic       appRunning,
  input wire logic       fanOn,
  input wire logic       fanFullSpeed,
  input wire logic       powerEnable,
  input wire logic [4:0] faultCode,
  input wire logic       fieldbusRateLoad,
  input wire logic [9:0] fieldbusRateKbps,
  input wire logic       status_indicator_a_red,
  input wire logic       status_indicator_a_green,
  input wire logic       status_indicator_b
);
  localparam int FLASH_SPAN = int'(FLASH_CYC) + 1;
  logic [fts_pkg::CNT_W-1:0] sinceReset_reg;
  wire hiLoad = weldActive && (loadCurrentAmps > fts_pkg::HIGH_CURRENT_A);
  wire cutOpen = transformer_thermal_cutout || heatsink_thermal_cutout;
  wire thermFault = faultCode == fts_pkg::FAULT_THERMAL;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // saturates, so a long run never wraps back into the start-up window
  always_ff @(posedge sys_clk)
    if (reset)
      sinceReset_reg <= '0;
    else if (sinceReset_reg < DELAY_CYC + 64)
      sinceReset_reg <= sinceReset_reg + 1'b1;
  chk_fan_hold_off: assert property (
    sinceReset_reg < DELAY_CYC |-> !fanOn) else $error("fans early");
  chk_fan_blip_full: assert property (
    sinceReset_reg == DELAY_CYC + 4 |-> fanOn && fanFullSpeed)
    else $error("no blip");
  chk_high_load_full: assert property (
    hiLoad && fanOn |-> ##[1:2] fanFullSpeed) else $error("not full");
  chk_full_hold_time: assert property (
    $fell(hiLoad) && weldActive && fanFullSpeed |=> fanFullSpeed[*8])
    else $error("hold cut short");
  chk_runon_keeps_fans: assert property (
    $fell(weldActive) && fanOn |=> fanOn[*8]) else $error("run-on short");
  chk_overtemp_full: assert property (
    overTemp[*3] |-> fanOn && fanFullSpeed) else $error("hot, not full");
  chk_cutout_stops: assert property (
    cutOpen |=> !powerEnable && thermFault) else $error("no stop");
  chk_restart_refused: assert property (
    thermFault && (cutOpen || !restartRequest) |=> !powerEnable)
    else $error("restart let through");
  chk_rate_load_once: assert property (
    $fell(reset) |-> ##[1:2] (fieldbusRateLoad &&
    fieldbusRateKbps == fts_pkg::FIELDBUS_KBPS) ##1 !fieldbusRateLoad)
    else $error("bus rate load");
  chk_red_first: assert property (
    $fell(reset) |-> ##[1:2] status_indicator_a_red && !status_indicator_b)
    else $error("red lamp");
  chk_run_flash: assert property (
    appRunning[*8] |-> ##[0:FLASH_SPAN] !$stable(status_indicator_a_green))
    else $error("no flash");
endmodule : fts_supervisor_monitor
bind fts_supervisor fts_supervisor_monitor #(.DELAY_CYC(DELAY_CYC),
  .FLASH_CYC(FLASH_CYC)) i_mon (.*);
`default_nettype wire

// ---- test/fts_fan_model.sv ----
// Purpose: fans, thermal cutouts and temperature beside the board
// Assumes: bench commands change between clock edges
// Notes:   cools only at full fan speed
`timescale 1ns/1ps
`default_nettype none
module fts_fan_model (
  input  wire logic sys_clk,
  input  wire logic fanOn,
  input  wire logic fanFullSpeed,
  input  wire logic heatUp,
  input  wire logic openXfmr,
  input  wire logic openSink,
  output logic      overTemp = 1'b0,
  output logic      transformer_thermal_cutout = 1'b0,
  output logic      heatsink_thermal_cutout = 1'b0
);
  // low speed is too weak to bring the temperature back down
  always @(posedge sys_clk)
  begin
    transformer_thermal_cutout <= openXfmr;
    heatsink_thermal_cutout <= openSink;
    if (heatUp)
      overTemp <= 1'b1;
    else if (fanOn && fanFullSpeed)
      overTemp <= 1'b0;
  end
endmodule : fts_fan_model
`default_nettype wire

// ---- test/tb_fan_thermal_supervisor.sv ----
// Purpose: self-checking bench for the fan and thermal supervisor
// Assumes: long counts shortened through parameters
// Notes:   notes are queued by the driver, checked on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_fan_thermal_supervisor;
  typedef struct {
    int          at;
    string       nm;
    logic [21:0] m;
    logic [21:0] v;
  } fts_note_t;
  localparam logic [21:0] M_FAN = 22'h000003;
  localparam logic [21:0] M_PWR = 22'h0000FC;
  localparam logic [21:0] M_LMP = 22'h3C0000;
  localparam logic [21:0] FAULT6 = 22'(fts_pkg::FAULT_THERMAL) << 3;
  logic       sys_clk = 1'b0;
  logic       reset, weldActive, restartRequest, appRunning;
  logic       heatUp, openXfmr, openSink;
  logic [9:0] loadCurrentAmps;
  logic [7:0] seed;
  wire logic  overTemp, transformer_thermal_cutout, heatsink_thermal_cutout;
  wire logic  fanOn, fanFullSpeed, powerEnable, fieldbusRateLoad;
  wire logic  status_indicator_a_red, status_indicator_a_green;
  wire logic  status_indicator_b, status_indicator_c;
  wire logic [4:0] faultCode;
  wire logic [9:0] fieldbusRateKbps;
  int         cycCount = 0;
  int         n_mismatch = 0;
  int         check_count = 0;
  fts_note_t  noteQ[$];
  fts_note_t  nt;
  wire logic [21:0] outs = {status_indicator_c, status_indicator_b,
    status_indicator_a_green, status_indicator_a_red, fieldbusRateKbps,
    faultCode, powerEnable, fanFullSpeed, fanOn};
  always #20 sys_clk = ~sys_clk;
  fts_supervisor #(.DELAY_CYC(10), .BLIP_CYC(5), .RUNON_CYC(20),
    .RED_CYC(5), .FLASH_CYC(3)) i_dut (.sys_clk, .reset, .weldActive,
    .loadCurrentAmps, .overTemp, .transformer_thermal_cutout,
    .heatsink_thermal_cutout, .restartRequest, .appRunning,
    .procBitRateKbps(fts_pkg::FIELDBUS_KBPS), .fanOn, .fanFullSpeed,
    .powerEnable, .faultCode, .fieldbusRateLoad, .fieldbusRateKbps,
    .status_indicator_a_red, .status_indicator_a_green,
    .status_indicator_b, .status_indicator_c);
  fts_fan_model i_fan (.sys_clk, .fanOn, .fanFullSpeed, .heatUp, .openXfmr,
    .openSink, .overTemp, .transformer_thermal_cutout,
    .heatsink_thermal_cutout);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic note(input int d, input string nm, input logic [21:0] m,
                      input logic [21:0] v);
    noteQ.push_back('{cycCount + d, nm, m, v});
  endtask : note
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic complete_run;
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // a hang ends here rather than running on silently
  always @(posedge sys_clk)
  begin
    cycCount++;
    if (cycCount == 600)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  always @(negedge sys_clk)
    while (noteQ.size() > 0 && noteQ[0].at <= cycCount)
    begin
      nt = noteQ.pop_front();
      check_count++;
      if ((outs & nt.m) !== nt.v)
      begin
        n_mismatch++;
        $display("Error %s expected %h seen %h", nt.nm, nt.v, outs & nt.m);
      end
    end
  initial
  begin
    reset = 1'b1;
    {weldActive, restartRequest, appRunning, heatUp, openXfmr, openSink} = '0;
    loadCurrentAmps = '0;
    seed = 8'h24;
    step(6);
    reset = 1'b0;
    note(3, "start lamps", M_LMP, 22'h040000);
    note(3, "bus rate", 22'h03FF00, 22'(fts_pkg::FIELDBUS_KBPS) << 8);
    note(5, "fans off", M_FAN, 22'h000000);
    note(12, "lamps green", M_LMP, 22'h380000);
    note(15, "fan blip", M_FAN, 22'h000003);
    note(24, "fans idle", M_FAN, 22'h000000);
    step(26);
    loadCurrentAmps = fts_pkg::HIGH_CURRENT_A;
    weldActive = 1'b1;
    note(4, "low speed", M_FAN, 22'h000001);
    step(5);
    loadCurrentAmps = fts_pkg::HIGH_CURRENT_A + 10'h001;
    note(4, "full speed", M_FAN, 22'h000003);
    step(5);
    seed = lfsr(seed);
    loadCurrentAmps = {3'h0, seed[6:0]};
    note(18, "full hold", M_FAN, 22'h000003);
    note(28, "back to low", M_FAN, 22'h000001);
    step(30);
    weldActive = 1'b0;
    note(18, "run-on", 22'h000001, 22'h000001);
    note(28, "run-on end", M_FAN, 22'h000000);
    step(30);
    heatUp = 1'b1;
    note(4, "hot fans", M_FAN, 22'h000003);
    step(5);
    heatUp = 1'b0;
    note(7, "cooled", M_FAN, 22'h000000);
    step(8);
    openSink = 1'b1;
    restartRequest = 1'b1;
    note(4, "sink trip", M_PWR, FAULT6);
    step(5);
    openSink = 1'b0;
    restartRequest = 1'b0;
    note(4, "stays stopped", M_PWR, FAULT6);
    step(5);
    restartRequest = 1'b1;
    note(4, "restart", M_PWR, 22'h000004);
    step(5);
    restartRequest = 1'b0;
    openXfmr = 1'b1;
    note(4, "transformer trip", M_PWR, FAULT6);
    step(5);
    openXfmr = 1'b0;
    restartRequest = 1'b1;
    note(5, "restart again", M_PWR, 22'h000004);
    step(6);
    appRunning = 1'b1;
    note(8, "flash off", 22'h380000, 22'h000000);
    note(12, "run lamps", 22'h3C0000, 22'h080000);
    step(14);
    complete_run();
  end
endmodule : tb_fan_thermal_supervisor
`default_nettype wire
